// >>> wfr_pkg.sv
// shared constants and types for the watchdog and fault response block
package wfr_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int TICK_US = 10;
  localparam int TICK_CYCLES = TICK_US * CLK_PER_US;
  localparam int SAMPLE_NS = 12_200;
  localparam int SAMPLE_CYCLES = (SAMPLE_NS * CLK_PER_US + 999) / 1000;
  localparam int CNT_W = 24;
  localparam int US_PER_MS = 1000;

  // interval limits, as steps of each register's rounding grid
  localparam int FIRST_STEP_US = 1000;
  localparam int FIRST_MAX_STEPS = 65_000;
  localparam int REP_STEP_US = 10;
  localparam int REP_MAX_STEPS = 65_500;
  localparam int PGD_STEP_US = 200;
  localparam int PGD_MAX_STEPS = 65_500;
  localparam int RETRY_STEP_US = 1000;
  localparam int RETRY_MAX_STEPS = 65_535;

  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_OV_RESP = 8'h41;
  localparam logic [7:0] CMD_UV_RESP = 8'h45;
  localparam logic [7:0] CMD_OC_RESP = 8'h47;
  localparam logic [7:0] CMD_UC_RESP = 8'h4C;
  localparam logic [7:0] CMD_OT_RESP = 8'h50;
  localparam logic [7:0] CMD_UT_RESP = 8'h54;
  localparam logic [7:0] CMD_VIN_OV_RESP = 8'h56;
  localparam logic [7:0] CMD_VIN_UV_RESP = 8'h5A;
  localparam logic [7:0] CMD_TON_RESP = 8'h63;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_STATUS_VOUT = 8'h7A;
  localparam logic [7:0] CMD_PWRGD_EN = 8'hD4;
  localparam logic [7:0] CMD_RETRY_DELAY = 8'hDB;
  localparam logic [7:0] CMD_PGD_DELAY = 8'hE1;
  localparam logic [7:0] CMD_WD_FIRST = 8'hE2;
  localparam logic [7:0] CMD_WD_REP = 8'hE3;
  localparam logic [7:0] CMD_RETRY_LIMIT = 8'hF7;
  localparam logic [7:0] PAGE_ALL = 8'hFF;

  localparam logic [7:0] RST_OV_RESP = 8'h80;
  localparam logic [7:0] RST_UV_RESP = 8'h7F;
  localparam logic [7:0] RST_TEMP_RESP = 8'hB8;
  localparam logic [7:0] RST_TON_RESP = 8'hB8;
  localparam logic [7:0] RST_VIN_OV_RESP = 8'h80;
  localparam logic [7:0] RST_ZERO_RESP = 8'h00;
  localparam logic [7:0] RST_RETRY_LIMIT = 8'h00;
  localparam logic [15:0] RST_RETRY_DELAY = 16'hF320;
  localparam logic [15:0] RST_PGD_DELAY = 16'hEB20;
  localparam logic [15:0] RST_WD_INTERVAL = 16'h8000;
  localparam logic [7:0] RST_PAGE = 8'h00;

  // response byte fields
  localparam int ACT_HI = 7;
  localparam int ACT_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DLY_HI = 2;
  localparam int DLY_LO = 0;
  localparam logic [1:0] ACT_DEGLITCH = 2'h1;
  localparam int PGEN_WDOG_BIT = 8;

  // status bit positions
  localparam int STW_VOUT = 15;
  localparam int STW_WDOG = 12;
  localparam int STB_VOUT_OV = 5;
  localparam int STV_OV = 7;
  localparam int STV_UV = 4;

  typedef enum logic [3:0] {
    WD_OFF = 4'h1,
    WD_WAITPG = 4'h2,
    WD_FIRST = 4'h4,
    WD_RUN = 4'h8
  } wfr_wd_state_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] data;
  } wfr_cmd_s;
endpackage

// >>> wfr_watchdog_fault.sv
// host watchdog, power-good gating and fault response control
// Operation
// - nonzero repeat-interval write restarts the watchdog
// - kick rising edge restarts; host kicks in time
// - expiry asserts alert; pulses power good low only when the watchdog bit is set
// - zero in either interval disables watchdog
// - gated power good: first interval after assertion
// - ungated: first interval after watchdog enable
// - first interval capped 65 s, 1 ms steps
// - later periods use the repeat interval
// - repeat interval capped 655 ms, 10 us
// - intervals counted on the internal clock
// - interval reads return the raw written value
// - latched fault released by control, operation, bias
// - any fault sets status, pulls alert low
// - clear faults wipes status, releases alert
// - clear faults keeps faulted-off channels off
// - voltage responses act on fast comparator detections
// - voltage fault sets word, vout status; byte bit for over-voltage only
// - response bytes reset to their defaults
// - retry interval word spaces restart attempts
// - global retry count limits restart attempts
// - action field: continue, deglitch-then-off, off
// - retry field: latch off or retry
// - delay field counts supervisor sample periods
// - watchdog bit ANDs watchdog into power good
`timescale 1ns/1ps
`default_nettype none
module wfr_watchdog_fault #(
  parameter int NUM_CH = 4,
  parameter int TICK_CYC = wfr_pkg::TICK_CYCLES,
  parameter int SAMPLE_CYC = wfr_pkg::SAMPLE_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire wfr_pkg::wfr_cmd_s cmd,
  output logic [15:0] rdData,
  output logic rdValid,
  output logic rdKnown,
  input wire logic kickInputPin,
  input wire logic controlPin,
  input wire logic inputSensePresent,
  input wire logic [NUM_CH-1:0] chanPowerGood,
  input wire logic [NUM_CH-1:0] ovDetect,
  input wire logic [NUM_CH-1:0] uvDetect,
  output logic powerGoodOut,
  output logic hostAlertOutN,
  output logic [NUM_CH-1:0] chanEnable,
  output logic [15:0] statusWord
);
  import wfr_pkg::*;

  localparam int IW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

  // rounds and clamps a linear-11 millisecond word into 10 us ticks
  function automatic logic [CNT_W-1:0] l11Ticks(input logic [15:0] w, input int stepUs, input int maxSteps);
    logic [4:0] e;
    logic [4:0] sh;
    logic [47:0] v;
    logic [16:0] s;
    e = w[15:11];
    sh = 5'h0;
    v = 48'(w[9:0]) * 48'(US_PER_MS / stepUs);
    if (e[4])
    begin
      sh = 5'(~e + 5'h1);
      v = (v + (48'h1 << (sh - 5'h1))) >> sh;
    end
    else
    begin
      v = v << e;
    end
    if (w[10])
      s = 17'h0;
    else if (v > 48'(maxSteps))
      s = 17'(maxSteps);
    else
      s = v[16:0];
    if (!w[10] && (w[9:0] != 10'h0) && (s == 17'h0))
      s = 17'h1;
    l11Ticks = CNT_W'(s) * CNT_W'(stepUs / TICK_US);
  endfunction

  logic [7:0] page;
  logic pgEnWdog;
  logic [NUM_CH-1:0] pgEnChan;
  logic [15:0] pgDelayRaw, wdFirstRaw, wdRepRaw, retryDelay;
  logic [7:0] vinOvResp, vinUvResp, retryLimit;
  logic [7:0] ovResp [NUM_CH];
  logic [7:0] uvResp [NUM_CH];
  logic [7:0] ocResp [NUM_CH];
  logic [7:0] ucResp [NUM_CH];
  logic [7:0] otResp [NUM_CH];
  logic [7:0] utResp [NUM_CH];
  logic [7:0] tonResp [NUM_CH];
  logic [NUM_CH-1:0] statusOv, statusUv, next_statusOv, next_statusUv, releaseVec, latched;
  logic statusWdog, next_statusWdog;
  logic [CNT_W-1:0] firstTicks, repTicks, pgdTicks, retryTicks, wdCount, pgCount;
  logic [15:0] tickDiv, sampleDiv;
  logic tick, sampleStb, kickPrev, kickRise, ctrlPrev, controlToggle, senseprev, biasRise;
  logic wrCmd, rdCmd, opWrite, clearFaults, wrRepNz, repWritePend, wdRestart, wdEnabled, wdExpire;
  logic wdExpired, pgPrev, pgFell, pgValid, pageOk;
  wfr_wd_state_e wdState;
  logic [IW-1:0] rdIdx;
  logic [15:0] next_rdData;
  logic next_rdKnown;

  assign wrCmd = cmd.valid && cmd.write;
  assign rdCmd = cmd.valid && !cmd.write;
  assign opWrite = wrCmd && (cmd.code == CMD_OPERATION);
  assign clearFaults = wrCmd && (cmd.code == CMD_CLEAR_FAULTS);
  assign wrRepNz = wrCmd && (cmd.code == CMD_WD_REP) && (l11Ticks(cmd.data, REP_STEP_US, REP_MAX_STEPS) != '0);
  assign kickRise = kickInputPin && !kickPrev;
  assign controlToggle = controlPin ^ ctrlPrev;
  assign biasRise = inputSensePresent && !senseprev;

  assign firstTicks = l11Ticks(wdFirstRaw, FIRST_STEP_US, FIRST_MAX_STEPS);
  assign repTicks = l11Ticks(wdRepRaw, REP_STEP_US, REP_MAX_STEPS);
  assign pgdTicks = l11Ticks(pgDelayRaw, PGD_STEP_US, PGD_MAX_STEPS);
  assign retryTicks = l11Ticks(retryDelay, RETRY_STEP_US, RETRY_MAX_STEPS);

  // internal timebase, never the shared clock
  assign tick = (tickDiv == 16'(TICK_CYC - 1));
  assign sampleStb = (sampleDiv == 16'(SAMPLE_CYC - 1));
  always_ff @(posedge clk)
  begin
    if (reset || tick)
      tickDiv <= 16'h0;
    else
      tickDiv <= tickDiv + 16'h1;
    if (reset || sampleStb)
      sampleDiv <= 16'h0;
    else
      sampleDiv <= sampleDiv + 16'h1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      kickPrev <= 1'b0;
      ctrlPrev <= 1'b0;
      // bias is taken as present out of reset, so no false release edge
      senseprev <= 1'b1;
      pgPrev <= 1'b0;
      repWritePend <= 1'b0;
    end
    else
    begin
      kickPrev <= kickInputPin;
      ctrlPrev <= controlPin;
      senseprev <= inputSensePresent;
      pgPrev <= powerGoodOut;
      repWritePend <= wrRepNz;
    end
  end

  // unpaged registers, stored exactly as written except CMD_PWRGD_EN, which keeps only its watchdog and channel enable bits
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      page <= RST_PAGE;
      pgEnWdog <= 1'b0;
      pgEnChan <= '0;
      pgDelayRaw <= RST_PGD_DELAY;
      wdFirstRaw <= RST_WD_INTERVAL;
      wdRepRaw <= RST_WD_INTERVAL;
      retryDelay <= RST_RETRY_DELAY;
      vinOvResp <= RST_VIN_OV_RESP;
      vinUvResp <= RST_ZERO_RESP;
      retryLimit <= RST_RETRY_LIMIT;
    end
    else if (wrCmd)
    begin
      case (cmd.code)
        CMD_PAGE: page <= cmd.data[7:0];
        CMD_PWRGD_EN:
        begin
          pgEnWdog <= cmd.data[PGEN_WDOG_BIT];
          pgEnChan <= cmd.data[NUM_CH-1:0];
        end
        CMD_PGD_DELAY: pgDelayRaw <= cmd.data;
        CMD_WD_FIRST: wdFirstRaw <= cmd.data;
        CMD_WD_REP: wdRepRaw <= cmd.data;
        CMD_RETRY_DELAY: retryDelay <= cmd.data;
        CMD_VIN_OV_RESP: vinOvResp <= cmd.data[7:0];
        CMD_VIN_UV_RESP: vinUvResp <= cmd.data[7:0];
        CMD_RETRY_LIMIT: retryLimit <= cmd.data[7:0];
        default: ;
      endcase
    end
  end

  assign wdEnabled = (firstTicks != '0) && (repTicks != '0);
  assign wdRestart = kickRise || repWritePend;
  assign pgFell = pgPrev && !powerGoodOut;
  assign wdExpire = wdEnabled && ((wdState == WD_FIRST) || (wdState == WD_RUN)) && !(pgEnWdog && pgFell)
                    && !wdRestart && tick && (wdCount <= CNT_W'(1));

  always_ff @(posedge clk)
  begin
    if (reset || !wdEnabled)
    begin
      wdState <= WD_OFF;
      wdCount <= '0;
      wdExpired <= 1'b0;
    end
    else
    begin
      case (wdState)
        WD_OFF:
        begin
          if (pgEnWdog)
            wdState <= WD_WAITPG;
          else
          begin
            wdState <= WD_FIRST;
            wdCount <= firstTicks;
          end
        end
        WD_WAITPG:
        begin
          if (!pgEnWdog || powerGoodOut)
          begin
            wdState <= WD_FIRST;
            wdCount <= firstTicks;
          end
        end
        WD_FIRST, WD_RUN:
        begin
          if (pgEnWdog && pgFell)
            wdState <= WD_WAITPG;
          else if (wdRestart)
          begin
            wdState <= WD_RUN;
            wdCount <= repTicks;
            wdExpired <= 1'b0;
          end
          else if (wdExpire)
          begin
            wdState <= WD_RUN;
            wdCount <= repTicks;
            wdExpired <= 1'b1;
          end
          else if (tick)
            wdCount <= wdCount - CNT_W'(1);
        end
        default: wdState <= WD_OFF;
      endcase
    end
  end

  // power good: enabled channels; a gated watchdog expiry drops it until the power-good delay runs out
  assign pgValid = (&(chanPowerGood | ~pgEnChan)) && !(pgEnWdog && wdExpire);
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      powerGoodOut <= 1'b0;
      pgCount <= '0;
    end
    else if (!pgValid)
    begin
      powerGoodOut <= 1'b0;
      pgCount <= pgdTicks;
    end
    else if (!powerGoodOut)
    begin
      if (pgCount == '0)
        powerGoodOut <= 1'b1;
      else if (tick)
        pgCount <= pgCount - CNT_W'(1);
    end
  end

  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    logic pageHit, det, trip, waiting;
    logic [7:0] resp;
    logic [2:0] glitch, retriesUsed;
    logic [CNT_W-1:0] retryTimer;
    assign pageHit = (page == 8'(i)) || (page == PAGE_ALL);
    assign releaseVec[i] = controlToggle || biasRise || (opWrite && pageHit);
    assign latched[i] = !chanEnable[i] && !waiting;

    always_ff @(posedge clk)
    begin
      if (reset)
      begin
        ovResp[i] <= RST_OV_RESP;
        uvResp[i] <= RST_UV_RESP;
        ocResp[i] <= RST_ZERO_RESP;
        ucResp[i] <= RST_ZERO_RESP;
        otResp[i] <= RST_TEMP_RESP;
        utResp[i] <= RST_TEMP_RESP;
        tonResp[i] <= RST_TON_RESP;
      end
      else if (wrCmd && pageHit)
      begin
        case (cmd.code)
          CMD_OV_RESP: ovResp[i] <= cmd.data[7:0];
          CMD_UV_RESP: uvResp[i] <= cmd.data[7:0];
          CMD_OC_RESP: ocResp[i] <= cmd.data[7:0];
          CMD_UC_RESP: ucResp[i] <= cmd.data[7:0];
          CMD_OT_RESP: otResp[i] <= cmd.data[7:0];
          CMD_UT_RESP: utResp[i] <= cmd.data[7:0];
          CMD_TON_RESP: tonResp[i] <= cmd.data[7:0];
          default: ;
        endcase
      end
    end

    // fast comparator detections, over-voltage taking precedence
    assign det = ovDetect[i] || uvDetect[i];
    assign resp = ovDetect[i] ? ovResp[i] : uvResp[i];
    always_ff @(posedge clk)
    begin
      if (reset || !det)
        glitch <= 3'h0;
      else if (sampleStb && (glitch != 3'h7))
        glitch <= glitch + 3'h1;
    end
    assign trip = chanEnable[i] && det && (resp[ACT_HI]
                  || ((resp[ACT_HI:ACT_LO] == ACT_DEGLITCH) && (glitch >= resp[DLY_HI:DLY_LO])));

    always_ff @(posedge clk)
    begin
      if (reset || releaseVec[i])
      begin
        chanEnable[i] <= 1'b1;
        waiting <= 1'b0;
        retriesUsed <= 3'h0;
        retryTimer <= '0;
      end
      else if (trip)
      begin
        chanEnable[i] <= 1'b0;
        if ((resp[RETRY_HI:RETRY_LO] != 3'h0) && (retriesUsed < retryLimit[2:0]))
        begin
          waiting <= 1'b1;
          retryTimer <= retryTicks;
          retriesUsed <= retriesUsed + 3'h1;
        end
        else
          waiting <= 1'b0;
      end
      else if (waiting && tick)
      begin
        if (retryTimer <= CNT_W'(1))
        begin
          chanEnable[i] <= 1'b1;
          waiting <= 1'b0;
        end
        else
          retryTimer <= retryTimer - CNT_W'(1);
      end
    end
  end

  // sticky status; a new event wins over a clear in the same cycle
  always_comb
  begin
    next_statusOv = (statusOv & ~{NUM_CH{clearFaults}}) | ovDetect;
    next_statusUv = (statusUv & ~{NUM_CH{clearFaults}}) | uvDetect;
    next_statusWdog = (statusWdog && !clearFaults) || wdExpire;
  end
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      statusOv <= '0;
      statusUv <= '0;
      statusWdog <= 1'b0;
      statusWord <= 16'h0;
      hostAlertOutN <= 1'b1;
    end
    else
    begin
      statusOv <= next_statusOv;
      statusUv <= next_statusUv;
      statusWdog <= next_statusWdog;
      statusWord <= 16'h0;
      statusWord[STW_VOUT] <= |(next_statusOv | next_statusUv);
      statusWord[STB_VOUT_OV] <= |next_statusOv;
      statusWord[STW_WDOG] <= next_statusWdog;
      hostAlertOutN <= !(|(next_statusOv | next_statusUv) || next_statusWdog);
    end
  end

  assign rdIdx = page[IW-1:0];
  assign pageOk = (page < 8'(NUM_CH));
  always_comb
  begin
    next_rdData = 16'h0;
    next_rdKnown = 1'b1;
    case (cmd.code)
      CMD_PAGE: next_rdData = {8'h0, page};
      CMD_OV_RESP: next_rdData = {8'h0, ovResp[rdIdx]};
      CMD_UV_RESP: next_rdData = {8'h0, uvResp[rdIdx]};
      CMD_OC_RESP: next_rdData = {8'h0, ocResp[rdIdx]};
      CMD_UC_RESP: next_rdData = {8'h0, ucResp[rdIdx]};
      CMD_OT_RESP: next_rdData = {8'h0, otResp[rdIdx]};
      CMD_UT_RESP: next_rdData = {8'h0, utResp[rdIdx]};
      CMD_TON_RESP: next_rdData = {8'h0, tonResp[rdIdx]};
      CMD_STATUS_VOUT:
      begin
        next_rdData[STV_OV] = statusOv[rdIdx];
        next_rdData[STV_UV] = statusUv[rdIdx];
      end
      CMD_VIN_OV_RESP: next_rdData = {8'h0, vinOvResp};
      CMD_VIN_UV_RESP: next_rdData = {8'h0, vinUvResp};
      CMD_STATUS_BYTE: next_rdData = {8'h0, statusWord[7:0]};
      CMD_STATUS_WORD: next_rdData = statusWord;
      CMD_PWRGD_EN:
      begin
        next_rdData[PGEN_WDOG_BIT] = pgEnWdog;
        next_rdData[NUM_CH-1:0] = pgEnChan;
      end
      CMD_PGD_DELAY: next_rdData = pgDelayRaw;
      CMD_WD_FIRST: next_rdData = wdFirstRaw;
      CMD_WD_REP: next_rdData = wdRepRaw;
      CMD_RETRY_DELAY: next_rdData = retryDelay;
      CMD_RETRY_LIMIT: next_rdData = {8'h0, retryLimit};
      default: next_rdKnown = 1'b0;
    endcase
    if ((cmd.code inside {CMD_OV_RESP, CMD_UV_RESP, CMD_OC_RESP, CMD_UC_RESP, CMD_OT_RESP, CMD_UT_RESP,
                          CMD_TON_RESP, CMD_STATUS_VOUT}) && !pageOk)
      next_rdKnown = 1'b0;
  end
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rdData <= 16'h0;
      rdValid <= 1'b0;
      rdKnown <= 1'b0;
    end
    else
    begin
      rdValid <= rdCmd;
      if (rdCmd)
      begin
        rdData <= next_rdData;
        rdKnown <= next_rdKnown;
      end
    end
  end

  property p_write_restart;
    @(posedge clk) disable iff (reset)
    wrRepNz ##1 (wdEnabled && !pgFell && ((wdState == WD_FIRST) || (wdState == WD_RUN)))
    |=> (wdState == WD_RUN) && (wdCount == $past(repTicks)) && !wdExpired;
  endproperty
  a_write_restart: assert property (p_write_restart) else $error("repeat write did not restart");
  property p_kick_restart;
    @(posedge clk) disable iff (reset)
    (kickRise && wdEnabled && !pgFell && ((wdState == WD_FIRST) || (wdState == WD_RUN)))
    |=> (wdState == WD_RUN) && (wdCount == $past(repTicks)) && !wdExpired;
  endproperty
  a_kick_restart: assert property (p_kick_restart) else $error("kick did not restart");
  property p_expire;
    @(posedge clk) disable iff (reset)
    wdExpire |=> wdExpired && !hostAlertOutN && (!$past(pgEnWdog) || !powerGoodOut) && (wdCount == $past(repTicks));
  endproperty
  a_expire: assert property (p_expire) else $error("expiry response missing");
  property p_disable;
    @(posedge clk) disable iff (reset)
    !wdEnabled |=> (wdState == WD_OFF) && !wdExpired;
  endproperty
  a_disable: assert property (p_disable) else $error("watchdog not disabled");
  property p_first_load;
    @(posedge clk) disable iff (reset)
    (wdState == WD_FIRST) && ($past(wdState) != WD_FIRST) |-> wdCount == $past(firstTicks);
  endproperty
  a_first_load: assert property (p_first_load) else $error("first interval not loaded");
  property p_clamps;
    @(posedge clk) disable iff (reset)
    (firstTicks <= CNT_W'(FIRST_MAX_STEPS * (FIRST_STEP_US / TICK_US))) && (repTicks <= CNT_W'(REP_MAX_STEPS));
  endproperty
  a_clamps: assert property (p_clamps) else $error("interval above its limit");
  property p_readback;
    @(posedge clk) disable iff (reset)
    (rdCmd && (cmd.code == CMD_WD_FIRST)) |=> rdValid && (rdData == $past(wdFirstRaw));
  endproperty
  a_readback: assert property (p_readback) else $error("first interval read mismatch");
  property p_status;
    @(posedge clk) disable iff (reset)
    ovDetect[0] |=> statusWord[STW_VOUT] && statusWord[STB_VOUT_OV] && statusOv[0] && !hostAlertOutN;
  endproperty
  a_status: assert property (p_status) else $error("fault status not set");
  property p_clear;
    @(posedge clk) disable iff (reset)
    (clearFaults && (ovDetect == '0) && (uvDetect == '0) && !wdExpire) |=> hostAlertOutN && (statusWord == 16'h0);
  endproperty
  a_clear: assert property (p_clear) else $error("clear faults left alert");
  property p_clear_keeps_off;
    @(posedge clk) disable iff (reset)
    (clearFaults && latched[0] && !releaseVec[0]) |=> latched[0];
  endproperty
  a_clear_keeps_off: assert property (p_clear_keeps_off) else $error("clear faults released channel");
  property p_trip;
    @(posedge clk) disable iff (reset)
    (chanEnable[0] && ovDetect[0] && ovResp[0][ACT_HI] && !releaseVec[0]) |=> !chanEnable[0];
  endproperty
  a_trip: assert property (p_trip) else $error("immediate shutdown missed");
  property p_defaults;
    @(posedge clk) disable iff (reset)
    $past(reset) |-> (ovResp[0] == RST_OV_RESP) && (uvResp[0] == RST_UV_RESP)
      && (otResp[0] == RST_TEMP_RESP) && (tonResp[0] == RST_TON_RESP) && (ocResp[0] == RST_ZERO_RESP)
      && (vinOvResp == RST_VIN_OV_RESP) && (vinUvResp == RST_ZERO_RESP);
  endproperty
  a_defaults: assert property (p_defaults) else $error("response reset value wrong");
endmodule
`default_nettype wire

// >>> wfr_host_model.sv
// host-side model that kicks the watchdog input at a steady pace
`timescale 1ns/1ps
`default_nettype none
module wfr_host_model #(
  parameter int HALF = 100
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic kickOn,
  output logic kickInputPin
);
  int cnt;
  // square wave, one rising edge every 2*HALF cycles
  always_ff @(posedge clk)
  begin
    if (reset || !kickOn)
    begin
      cnt <= 0;
      kickInputPin <= 1'b0;
    end
    else if (cnt == HALF - 1)
    begin
      cnt <= 0;
      kickInputPin <= ~kickInputPin;
    end
    else
      cnt <= cnt + 1;
  end
endmodule
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the watchdog and fault response block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import wfr_pkg::*;
  localparam int TK = 4;
  localparam int WD = 100 * TK;
  logic clk = 1'b0;
  logic reset = 1'b1;
  wfr_cmd_s cmd = '0;
  logic [15:0] rdData, statusWord;
  logic rdValid, rdKnown, kickInputPin, powerGoodOut, hostAlertOutN;
  logic kickOn = 1'b0;
  logic controlPin = 1'b0;
  logic inputSensePresent = 1'b1;
  logic [3:0] ovDetect = 4'h0;
  logic [3:0] chanEnable;
  int num_errors = 0;
  int n_tests = 0;
  always #20 clk = ~clk;
  wfr_watchdog_fault #(.TICK_CYC(TK), .SAMPLE_CYC(3)) uut (.clk(clk), .reset(reset), .cmd(cmd),
    .rdData(rdData), .rdValid(rdValid), .rdKnown(rdKnown), .kickInputPin(kickInputPin),
    .controlPin(controlPin), .inputSensePresent(inputSensePresent), .chanPowerGood(4'hF), .ovDetect(ovDetect),
    .uvDetect(4'h0), .powerGoodOut(powerGoodOut), .hostAlertOutN(hostAlertOutN),
    .chanEnable(chanEnable), .statusWord(statusWord));
  wfr_host_model #(.HALF(100)) host (.clk(clk), .reset(reset), .kickOn(kickOn), .kickInputPin(kickInputPin));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    cmd <= '{1'b1, 1'b1, c, d};
    @(posedge clk);
    cmd.valid <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e, input logic k);
    @(posedge clk);
    cmd <= '{1'b1, 1'b0, c, 16'h0000};
    @(posedge clk);
    cmd.valid <= 1'b0;
    #1;
    repeat (3) if (rdValid !== 1'b1) @(posedge clk) #1;
    chk("rdValid", 16'h0001, {15'h0000, rdValid});
    chk("rdKnown", {15'h0000, k}, {15'h0000, rdKnown});
    chk("rdData", e, rdData);
  endtask
  task automatic t_defaults;
    rd(CMD_OV_RESP, 16'h0080, 1'b1);
    rd(CMD_UV_RESP, 16'h007F, 1'b1);
    rd(CMD_OC_RESP, 16'h0000, 1'b1);
    rd(CMD_UT_RESP, 16'h00B8, 1'b1);
    rd(CMD_TON_RESP, 16'h00B8, 1'b1);
    rd(CMD_VIN_OV_RESP, 16'h0080, 1'b1);
    rd(CMD_VIN_UV_RESP, 16'h0000, 1'b1);
    rd(CMD_RETRY_DELAY, 16'hF320, 1'b1);
    rd(CMD_RETRY_LIMIT, 16'h0000, 1'b1);
    rd(8'h99, 16'h0000, 1'b0);
  endtask
  task automatic t_watchdog;
    wr(CMD_WD_FIRST, 16'h0002);
    wr(CMD_WD_REP, 16'h0001);
    rd(CMD_WD_FIRST, 16'h0002, 1'b1);
    wt(2 * WD - 40);
    chk("alert first", 16'h0001, {15'h0000, hostAlertOutN});
    wt(60);
    chk("alert expiry", 16'h0000, {15'h0000, hostAlertOutN});
    kickOn <= 1'b1;
    wt(150);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    wt(3 * WD);
    chk("alert kicked", 16'h0001, {15'h0000, hostAlertOutN});
    kickOn <= 1'b0;
    repeat (3)
    begin
      wt(WD - 100);
      wr(CMD_WD_REP, 16'h0001);
    end
    wt(1);
    chk("alert rewrite", 16'h0001, {15'h0000, hostAlertOutN});
    wt(WD + 20);
    chk("alert repeat", 16'h0000, {15'h0000, hostAlertOutN});
    chk("wdog status", 16'h1000, statusWord & 16'h1000);
    wr(CMD_WD_REP, 16'h0000);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    wt(3);
    chk("status clr", 16'h0000, statusWord);
    wt(2 * WD);
    chk("alert off", 16'h0001, {15'h0000, hostAlertOutN});
  endtask
  task automatic t_fault;
    wr(CMD_OV_RESP, 16'h00C0);
    rd(CMD_OV_RESP, 16'h00C0, 1'b1);
    ovDetect <= 4'h1;
    wt(3);
    chk("chanEnable trip", 16'h000E, {12'h000, chanEnable});
    chk("status ov", 16'h8020, statusWord & 16'h8020);
    chk("alert ov", 16'h0000, {15'h0000, hostAlertOutN});
    rd(CMD_STATUS_VOUT, 16'h0080, 1'b1);
    ovDetect <= 4'h0;
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    wt(3);
    chk("alert clr", 16'h0001, {15'h0000, hostAlertOutN});
    chk("chanEnable kept", 16'h000E, {12'h000, chanEnable});
    controlPin <= 1'b1;
    wt(3);
    chk("chanEnable rel", 16'h000F, {12'h000, chanEnable});
    ovDetect <= 4'h1;
    wt(3);
    ovDetect <= 4'h0;
    inputSensePresent <= 1'b0;
    wt(2);
    chk("chanEnable bias off", 16'h000E, {12'h000, chanEnable});
    inputSensePresent <= 1'b1;
    wt(3);
    chk("chanEnable bias", 16'h000F, {12'h000, chanEnable});
  endtask
  task automatic t_pgood;
    wr(CMD_PGD_DELAY, 16'h0001);
    wr(CMD_PWRGD_EN, 16'h0100);
    rd(CMD_PWRGD_EN, 16'h0100, 1'b1);
    wr(CMD_WD_REP, 16'h0001);
    wt(2 * WD - 40);
    chk("pg first", 16'h0001, {15'h0000, powerGoodOut});
    wt(60);
    chk("pg drop", 16'h0000, {15'h0000, powerGoodOut});
    wt(WD);
    chk("pg back", 16'h0001, {15'h0000, powerGoodOut});
    wt(WD + 100);
    chk("pg first again", 16'h0001, {15'h0000, powerGoodOut});
    wr(CMD_WD_REP, 16'h0000);
    wr(CMD_PWRGD_EN, 16'h0000);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    wt(3);
    chk("alert pg clr", 16'h0001, {15'h0000, hostAlertOutN});
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #400000;
    num_errors++;
    end_of_test();
  end
  initial
  begin
    wt(10);
    reset <= 1'b0;
    t_defaults();
    t_watchdog();
    t_fault();
    t_pgood();
    end_of_test();
  end
endmodule
`default_nettype wire
